// >>> core/clk_pm_pkg.sv
package clk_pm_pkg;

    // ------------------------------------------------------------
    // register map, byte offsets on the apb bus
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;

    // control word width and layout
    localparam int CTRL_W = 11;
    localparam int ALL_STOP_BIT = 11;
    localparam logic [10:0] CTRL_RST = 11'h106;

    // status word layout
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_MAIN_RUN_BIT = 2;
    localparam int STAT_HSO_SRC_BIT = 3;
    localparam int STAT_LSO_RUN_BIT = 4;

    // ------------------------------------------------------------
    // timing and division constants
    // ------------------------------------------------------------
    localparam logic [4:0] CPU_DIV1 = 5'h01;
    localparam logic [4:0] CPU_DIV2 = 5'h02;
    localparam logic [4:0] CPU_DIV4 = 5'h04;
    localparam logic [4:0] CPU_DIV8 = 5'h08;
    localparam logic [4:0] CPU_DIV16 = 5'h10;
    localparam int PERIPH_DIV2 = 2;
    localparam int PERIPH_DIV4 = 4;
    localparam int PERIPH_DIV8 = 8;
    localparam int PERIPH_DIV32 = 32;
    localparam int ONCHIP_DIV = 128;
    localparam int PERIPH_CLKS = 5;

    // ------------------------------------------------------------
    // wake-up source indices
    // ------------------------------------------------------------
    localparam int WK_KEY = 0;
    localparam int WK_EXT0 = 1;
    localparam int WK_EXT1 = 2;
    localparam int WK_EXT3 = 3;
    localparam int WK_TIMER_X = 4;
    localparam int WK_SERIAL = 5;
    localparam int WK_VMON2 = 6;
    localparam int WK_SSU = 7;
    localparam int WK_ADC = 8;
    localparam int WK_TIMER_Z = 9;
    localparam int WK_TIMER_C = 10;
    localparam int WK_OSC_STOP = 11;
    localparam int WK_WDT = 12;
    localparam int NSRC = 13;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_NORMAL,
        PM_WAIT,
        PM_STOP
    } pm_state_e;

    // control fields, msb first, matches bits 10..0 of the ctrl word
    typedef struct packed {
        logic hso_select;
        logic hso_enable;
        logic osc_source_select;
        logic [1:0] sys_div_sel;
        logic xtal_drive_high;
        logic lso_stop;
        logic xtal_pin_enable;
        logic div8_select;
        logic main_osc_stop;
        logic periph_clk_wait_stop;
    } ctrl_s;

    // peripheral operating conditions that decide wake eligibility
    typedef struct packed {
        logic ext_irq_zero_filter_on;
        logic ext_irq_three_filter_on;
        logic ext_irq3_timer_route;
        logic timer_x_event_mode;
        logic serial_ext_clk;
        logic vmon2_filter_bypass;
        logic adc_one_shot;
        logic wdt_protect_mode;
    } wake_cond_s;

endpackage : clk_pm_pkg

// >>> core/tick_div.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// fixed divider of a tick stream, one output tick per DIV inputs
// ------------------------------------------------------------
module tick_div #(
    parameter int unsigned DIV = 2
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick_in,
    output logic tick_out
);
    localparam int unsigned CW = $clog2(DIV);

    logic [CW-1:0] cnt_q;

    // count input ticks, emit a tick on wrap
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (cnt_q == CW'(DIV - 1)) begin
                    cnt_q <= '0;
                    tick_out <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

endmodule : tick_div

`default_nettype wire

// >>> core/clk_pm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module clk_pm_ctrl
    import clk_pm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator ticks, one mclk cycle each
    input wire logic main_osc_tick,
    input wire logic lso_osc_tick,
    input wire logic hso_osc_tick,
    // cpu and interrupt side
    input wire logic wait_exec,
    input wire logic [NSRC-1:0] irq_req,
    input wire logic [NSRC-1:0] irq_prio_nz,
    input wire logic global_irq_enable,
    input wire wake_cond_s wake_cond,
    // clock outputs as tick streams
    output logic cpu_clk_tick,
    output logic wdt_clk_tick,
    output logic [PERIPH_CLKS-1:0] periph_div_clk,
    output logic onchip_osc_clk_tap,
    output logic onchip_osc_clk_div128,
    output logic hso_raw_clk,
    output logic lso_safety_clk,
    // oscillator and pin control, wake indication
    output logic main_osc_run,
    output logic lso_run,
    output logic hso_run,
    output logic xout_high,
    output logic pin_hold,
    output logic wake_pulse
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ctrl_s ctrl_q;
    pm_state_e state_q;
    logic [4:0] div_q;
    logic [4:0] div_d;
    logic [4:0] cpu_cnt_q;
    logic wr_ctrl;
    logic stop_req;
    logic acc_ok;
    logic in_stop;
    logic in_wait;
    logic main_ok;
    logic lso_ok;
    logic hso_ok;
    logic onchip_tick;
    logic sys_tick;
    logic periph_gate;
    logic periph_src;
    logic cpu_raw;
    logic lso_raw;
    logic ring128_raw;
    logic [PERIPH_CLKS-1:1] pdiv_raw;
    logic [NSRC-1:0] elig;
    logic wake_req;
    logic cpu_clk_q;
    logic wdt_clk_q;
    logic [PERIPH_CLKS-1:0] periph_q;
    logic ring_q;
    logic ring128_q;
    logic hso_clk_q;
    logic lso_clk_q;
    logic wake_q;
    logic hold_q;
    logic xout_q;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------

    // only the two word offsets are mapped
    always_comb begin
        if (paddr == CTRL_OFS) begin
            acc_ok = 1'b1;
        end else if (paddr == STAT_OFS) begin
            acc_ok = 1'b1;
        end else begin
            acc_ok = 1'b0;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~acc_ok;
    assign wr_ctrl = psel & penable & pwrite & (paddr == CTRL_OFS);
    // stop request ignored in watchdog protect mode
    assign stop_req = wr_ctrl & pwdata[ALL_STOP_BIT] & ~wake_cond.wdt_protect_mode;

    // read data captured in the setup phase
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable) begin
            if (paddr == CTRL_OFS) begin
                prdata <= {21'h000000, ctrl_q};
            end else if (paddr == STAT_OFS) begin
                prdata <= 32'h0000_0000;
                prdata[STAT_STATE_LSB +: 2] <= state_q;
                prdata[STAT_MAIN_RUN_BIT] <= main_ok;
                prdata[STAT_HSO_SRC_BIT] <= ctrl_q.hso_select;
                prdata[STAT_LSO_RUN_BIT] <= lso_ok;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= ctrl_s'(CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_q <= ctrl_s'(pwdata[CTRL_W-1:0]);
            // slow oscillator cannot be stopped under protect mode
            if (wake_cond.wdt_protect_mode) begin
                ctrl_q.lso_stop <= ctrl_q.lso_stop;
            end
            if (stop_req && state_q == PM_NORMAL) begin
                ctrl_q.div8_select <= 1'b1;
                ctrl_q.xtal_drive_high <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------

    // wake eligibility per source for wait and stop
    always_comb begin
        elig = '0;
        if (state_q == PM_WAIT && !ctrl_q.periph_clk_wait_stop) begin
            elig = '1;
            elig[WK_ADC] = wake_cond.adc_one_shot;
            elig[WK_WDT] = wake_cond.wdt_protect_mode;
        end else if (state_q == PM_WAIT) begin
            elig[WK_KEY] = 1'b1;
            elig[WK_EXT0] = ~wake_cond.ext_irq_zero_filter_on;
            elig[WK_EXT1] = 1'b1;
            elig[WK_EXT3] = ~wake_cond.ext_irq_three_filter_on;
            elig[WK_TIMER_X] = wake_cond.timer_x_event_mode;
            elig[WK_SERIAL] = wake_cond.serial_ext_clk;
            elig[WK_VMON2] = 1'b1;
            elig[WK_WDT] = wake_cond.wdt_protect_mode;
        end else if (state_q == PM_STOP) begin
            elig[WK_KEY] = 1'b1;
            elig[WK_EXT0] = ~wake_cond.ext_irq_zero_filter_on;
            elig[WK_EXT1] = 1'b1;
            elig[WK_EXT3] = ~wake_cond.ext_irq_three_filter_on &
                            wake_cond.ext_irq3_timer_route;
            elig[WK_TIMER_X] = wake_cond.timer_x_event_mode;
            elig[WK_SERIAL] = wake_cond.serial_ext_clk;
            elig[WK_VMON2] = wake_cond.vmon2_filter_bypass;
        end
    end

    assign wake_req = global_irq_enable & |(irq_req & irq_prio_nz & elig);

    // normal, wait and stop transitions
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= PM_NORMAL;
        end else begin
            case (state_q)
                PM_NORMAL: begin
                    if (stop_req) begin
                        state_q <= PM_STOP;
                    end else if (wait_exec) begin
                        state_q <= PM_WAIT;
                    end
                end
                PM_WAIT: begin
                    if (wake_req) begin
                        state_q <= PM_NORMAL;
                    end
                end
                PM_STOP: begin
                    if (wake_req) begin
                        state_q <= PM_NORMAL;
                    end
                end
                default: begin
                    state_q <= PM_NORMAL;
                end
            endcase
        end
    end

    // one-cycle wake indication to the cpu
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_req & (state_q != PM_NORMAL);
        end
    end

    // ------------------------------------------------------------
    // oscillator enables and source selection
    // ------------------------------------------------------------
    assign in_stop = (state_q == PM_STOP);
    assign in_wait = (state_q == PM_WAIT);

    assign main_ok = ~ctrl_q.main_osc_stop & ctrl_q.xtal_pin_enable & ~in_stop;
    assign lso_ok = ~ctrl_q.lso_stop & (~in_stop | wake_cond.wdt_protect_mode);
    assign hso_ok = ctrl_q.hso_enable & ~in_stop;

    assign onchip_tick = ctrl_q.hso_select ? (hso_ok & hso_osc_tick)
                                           : (lso_ok & lso_osc_tick & ~in_stop);

    assign sys_tick = ctrl_q.osc_source_select ? onchip_tick
                                               : (main_ok & main_osc_tick);

    // ------------------------------------------------------------
    // cpu clock divider
    // ------------------------------------------------------------

    always_comb begin
        if (ctrl_q.div8_select) begin
            div_d = CPU_DIV8;
        end else begin
            case (ctrl_q.sys_div_sel)
                2'b00: div_d = CPU_DIV1;
                2'b01: div_d = CPU_DIV2;
                2'b10: div_d = CPU_DIV4;
                default: div_d = CPU_DIV16;
            endcase
        end
    end

    // new ratio taken at period end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_cnt_q <= 5'h00;
            div_q <= CPU_DIV8;
        end else if (sys_tick) begin
            if (cpu_cnt_q >= div_q - 5'h01) begin
                cpu_cnt_q <= 5'h00;
                div_q <= div_d;
            end else begin
                cpu_cnt_q <= cpu_cnt_q + 5'h01;
            end
        end
    end

    assign cpu_raw = sys_tick & (cpu_cnt_q >= div_q - 5'h01);

    // ------------------------------------------------------------
    // peripheral and on-chip tap dividers
    // ------------------------------------------------------------

    assign periph_gate = in_wait & ctrl_q.periph_clk_wait_stop;
    assign periph_src = sys_tick & ~periph_gate;

    tick_div #(.DIV(PERIPH_DIV2)) u_f2 (
        .mclk(mclk),
        .rst(rst),
        .tick_in(periph_src),
        .tick_out(pdiv_raw[1])
    );

    tick_div #(.DIV(PERIPH_DIV4)) u_f4 (
        .mclk(mclk),
        .rst(rst),
        .tick_in(periph_src),
        .tick_out(pdiv_raw[2])
    );

    tick_div #(.DIV(PERIPH_DIV8)) u_f8 (
        .mclk(mclk),
        .rst(rst),
        .tick_in(periph_src),
        .tick_out(pdiv_raw[3])
    );

    tick_div #(.DIV(PERIPH_DIV32)) u_f32 (
        .mclk(mclk),
        .rst(rst),
        .tick_in(periph_src),
        .tick_out(pdiv_raw[4])
    );

    tick_div #(.DIV(ONCHIP_DIV)) u_ring128 (
        .mclk(mclk),
        .rst(rst),
        .tick_in(onchip_tick),
        .tick_out(ring128_raw)
    );

    assign lso_raw = lso_ok & lso_osc_tick;

    // ------------------------------------------------------------
    // registered clock outputs
    // ------------------------------------------------------------

    // cpu and watchdog clocks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_clk_q <= 1'b0;
            wdt_clk_q <= 1'b0;
        end else begin
            // cpu stops in wait and stop
            cpu_clk_q <= cpu_raw & (state_q == PM_NORMAL);
            wdt_clk_q <= wake_cond.wdt_protect_mode ? lso_raw
                                                    : (cpu_raw & (state_q == PM_NORMAL));
        end
    end

    // peripheral clocks, f1 gated directly; dividers freeze when gated
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            periph_q <= '0;
        end else begin
            periph_q[0] <= periph_src;
            periph_q[PERIPH_CLKS-1:1] <= pdiv_raw;
        end
    end

    // on-chip taps, never gated by wait
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ring_q <= 1'b0;
            ring128_q <= 1'b0;
            hso_clk_q <= 1'b0;
            lso_clk_q <= 1'b0;
        end else begin
            ring_q <= onchip_tick;
            ring128_q <= ring128_raw;
            hso_clk_q <= hso_ok & hso_osc_tick;
            lso_clk_q <= lso_raw;
        end
    end

    // ------------------------------------------------------------
    // pin control
    // ------------------------------------------------------------

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_q <= 1'b0;
            xout_q <= 1'b0;
        end else begin
            hold_q <= (state_q != PM_NORMAL) | stop_req | wait_exec;
            xout_q <= ctrl_q.xtal_pin_enable & (in_stop | ctrl_q.main_osc_stop);
        end
    end

    assign cpu_clk_tick = cpu_clk_q;
    assign wdt_clk_tick = wdt_clk_q;
    assign periph_div_clk = periph_q;
    assign onchip_osc_clk_tap = ring_q;
    assign onchip_osc_clk_div128 = ring128_q;
    assign hso_raw_clk = hso_clk_q;
    assign lso_safety_clk = lso_clk_q;
    assign main_osc_run = main_ok;
    assign lso_run = lso_ok;
    assign hso_run = hso_ok;
    assign xout_high = xout_q;
    assign pin_hold = hold_q;
    assign wake_pulse = wake_q;

endmodule : clk_pm_ctrl

`default_nettype wire

// >>> dv/osc_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// oscillator sources in front of the clock block
// ------------------------------------------------------------
module osc_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic main_osc_run,
    input wire logic lso_run,
    input wire logic hso_run,
    output logic main_osc_tick,
    output logic lso_osc_tick,
    output logic hso_osc_tick
);
    logic [3:0] ph_q;

    // free-running phase shared by all sources
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ph_q <= 4'h0;
        end else begin
            ph_q <= ph_q + 4'h1;
        end
    end

    assign main_osc_tick = main_osc_run && ph_q[0];
    assign hso_osc_tick = hso_run && ph_q[1:0] == 2'h3;
    assign lso_osc_tick = lso_run && ph_q[2:0] == 3'h5;
endmodule : osc_model

`default_nettype wire

// >>> dv/clk_pm_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// port checker of the clock and power block
// ------------------------------------------------------------
module clk_pm_properties
    import clk_pm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic wait_exec,
    input wire logic [NSRC-1:0] irq_req,
    input wire logic [NSRC-1:0] irq_prio_nz,
    input wire logic global_irq_enable,
    input wire logic lso_osc_tick,
    input wire logic hso_osc_tick,
    input wire logic cpu_clk_tick,
    input wire logic [PERIPH_CLKS-1:0] periph_div_clk,
    input wire logic onchip_osc_clk_tap,
    input wire logic onchip_osc_clk_div128,
    input wire logic hso_raw_clk,
    input wire logic lso_safety_clk,
    input wire logic pin_hold,
    input wire logic wake_pulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic gate_q;
    logic wr;

    // gating bit mirrored from control writes
    assign wr = psel && penable && pwrite && paddr == CTRL_OFS;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gate_q <= 1'b0;
        end else if (wr) begin
            gate_q <= pwdata[0];
        end
    end

    // low-power mode held for three cycles
    sequence held3;
        pin_hold ##1 pin_hold ##1 pin_hold;
    endsequence

    wait_entry_a: assert property (wait_exec && !pin_hold |=> pin_hold)
        else $error("wait request not taken");
    no_spur_a: assert property (!pin_hold && !wait_exec && !(wr && pwdata[ALL_STOP_BIT])
        |=> !pin_hold) else $error("low power without request");
    cpu_off_a: assert property (held3 |-> !cpu_clk_tick)
        else $error("cpu tick while held");
    pclk_off_a: assert property (held3 ##0 gate_q |-> periph_div_clk == '0)
        else $error("peripheral tick while gated");
    wake_cause_a: assert property ($rose(wake_pulse) |-> ($past(pin_hold) ||
        $past(pin_hold, 2)) && ($past(global_irq_enable) || $past(global_irq_enable, 2)))
        else $error("wake without enabled request");
    key_wake_a: assert property (pin_hold && $rose(irq_req[WK_KEY])
        && irq_prio_nz[WK_KEY] && global_irq_enable |-> ##[1:3] wake_pulse)
        else $error("key wake missing");
    hso_src_a: assert property (hso_raw_clk |-> $past(hso_osc_tick))
        else $error("fast tap without source");
    lso_src_a: assert property (lso_safety_clk |-> $past(lso_osc_tick))
        else $error("safety tick without source");
    tap128_a: assert property (onchip_osc_clk_div128 |-> $past(onchip_osc_clk_tap))
        else $error("div128 off the tap");
    f2_step_a: assert property (periph_div_clk[1] |-> $past(periph_div_clk[0]))
        else $error("f2 off f1");
    f32_step_a: assert property (periph_div_clk[4] |-> &periph_div_clk[3:1])
        else $error("f32 off the chain");
endmodule : clk_pm_properties

bind clk_pm_ctrl clk_pm_properties clk_pm_properties_inst (.*);

`default_nettype wire

// >>> dv/clk_pm_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// self-checking bench of the clock and power block
// ------------------------------------------------------------
module clk_pm_ctrl_bench
    import clk_pm_pkg::*;
;
    logic mclk, rst, psel, penable, pwrite, wait_exec, global_irq_enable, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NSRC-1:0] irq_req, irq_prio_nz;
    wake_cond_s wake_cond;
    logic pready, pslverr, cpu_clk_tick, wdt_clk_tick, onchip_osc_clk_tap;
    logic onchip_osc_clk_div128, hso_raw_clk, lso_safety_clk, main_osc_run, lso_run;
    logic hso_run, xout_high, pin_hold, wake_pulse, main_osc_tick, lso_osc_tick, hso_osc_tick;
    logic [PERIPH_CLKS-1:0] periph_div_clk;
    logic [15:0] seed;
    ctrl_s c;
    int n_errors, compares, i;
    int k [8];

    clk_pm_ctrl clk_pm_ctrl_inst (.*);
    osc_model osc_model_inst (.*);

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    // xorshift source of stimulus
    function automatic logic [15:0] nxt(input logic [15:0] x);
        x ^= x << 7;
        x ^= x >> 9;
        return x ^ (x << 8);
    endfunction : nxt

    // cpu division ratio from the control fields
    function automatic int rt(input logic [1:0] sel, input logic d8);
        return d8 ? 8 : sel == 2'h3 ? 16 : 1 << sel;
    endfunction : rt

    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic near(input string nm, input int e, input int g);
        compares++;
        if (g > e + 1 || g < e - 1) begin
            n_errors++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask : near

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (t = 0; t < 20; t++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (t == 20) begin
            n_errors++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    // counts source, cpu, f1, f32, tap, safety, watchdog and wake ticks
    task automatic cnt(input int n, input int src);
        logic [7:0] v;
        k = '{default: 0};
        repeat (n) begin
            @(posedge mclk);
            v[0] = src == 0 ? main_osc_tick : src == 1 ? lso_osc_tick : hso_osc_tick;
            v[7:1] = {wake_pulse, wdt_clk_tick, lso_safety_clk, onchip_osc_clk_tap,
                periph_div_clk[4], periph_div_clk[0], cpu_clk_tick};
            for (int j = 0; j < 8; j++) k[j] += int'(v[j] === 1'b1);
        end
    endtask : cnt

    task automatic meas(input int src, input int r);
        repeat (200) @(posedge mclk);
        cnt(640, src);
        near("cpu ticks", k[0] / r, k[1]);
        near("f1 ticks", k[0], k[2]);
        near("f32 ticks", k[0] / 32, k[3]);
    endtask : meas

    task automatic put(input int src, input logic [1:0] sel, input logic d8);
        c = '0;
        c.xtal_pin_enable = 1'b1;
        c.hso_enable = 1'b1;
        c.hso_select = src == 2;
        c.osc_source_select = src != 0;
        c.sys_div_sel = sel;
        c.div8_select = d8;
        apb(1'b1, CTRL_OFS, {21'h0, c});
    endtask : put

    initial begin
        {mclk, psel, penable, pwrite, wait_exec, global_irq_enable} = '0;
        {paddr, pwdata, irq_req, irq_prio_nz, wake_cond} = '0;
        {n_errors, compares} = '0;
        seed = 16'h56ea;
        rst = 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl reset", {21'h0, CTRL_RST}, rd);
        chk("main run", 32'h0, {31'h0, main_osc_run});
        meas(1, 8);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
        put(0, 2'h0, 1'b0);
        meas(0, 1);
        put(0, 2'h3, 1'b1);
        meas(0, 8);
        for (i = 0; i < 6; i++) begin
            seed = nxt(seed);
            put(seed % 3, seed[3:2], seed[4]);
            meas(seed % 3, rt(seed[3:2], seed[4]));
        end
        c = '0;
        c.osc_source_select = 1'b1;
        c.sys_div_sel = 2'h1;
        c.periph_clk_wait_stop = 1'b1;
        apb(1'b1, CTRL_OFS, {21'h0, c});
        irq_prio_nz <= '1;
        wait_exec <= 1'b1;
        @(posedge mclk);
        wait_exec <= 1'b0;
        @(posedge mclk);
        chk("hold", 32'h1, {31'h0, pin_hold});
        irq_req[WK_KEY] <= 1'b1;
        cnt(300, 1);
        chk("cpu in wait", 32'h0, k[1]);
        chk("wdt in wait", 32'h0, k[6]);
        chk("f1 in wait", 32'h0, k[2]);
        near("tap in wait", k[0], k[4]);
        near("safety in wait", k[0], k[5]);
        chk("masked wake", 32'h0, k[7]);
        irq_req <= 13'h1 << WK_SSU;
        global_irq_enable <= 1'b1;
        cnt(50, 1);
        chk("ssu wake", 32'h0, k[7]);
        irq_req <= 13'h1 << WK_KEY;
        cnt(20, 1);
        chk("key wake", 32'h1, k[7]);
        irq_req <= '0;
        meas(1, 2);
        put(0, 2'h2, 1'b0);
        apb(1'b1, CTRL_OFS, {20'h0, 1'b1, c});
        apb(1'b0, STAT_OFS, 32'h0);
        chk("stop state", 32'h2, {30'h0, rd[1:0]});
        chk("xout held high", 32'h1, {31'h0, xout_high});
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("forced bits", 32'h24, rd & 32'h24);
        cnt(200, 0);
        chk("ticks in stop", 32'h0, k[1] + k[2] + k[4]);
        irq_req <= 13'h1 << WK_EXT0;
        cnt(20, 0);
        chk("ext0 wake", 32'h1, k[7]);
        irq_req <= '0;
        meas(0, 8);
        irq_prio_nz <= '0;
        wake_cond.wdt_protect_mode <= 1'b1;
        apb(1'b1, CTRL_OFS, {20'h0, 1'b1, c});
        apb(1'b0, STAT_OFS, 32'h0);
        chk("stop refused", 32'h0, {30'h0, rd[1:0]});
        wait_exec <= 1'b1;
        @(posedge mclk);
        wait_exec <= 1'b0;
        irq_req <= '1;
        cnt(300, 1);
        near("wdt protected", k[0], k[6]);
        chk("cpu protected wait", 32'h0, k[1]);
        chk("zero prio wake", 32'h0, k[7]);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("reset leaves wait", 32'h0, {31'h0, pin_hold});
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl after reset", {21'h0, CTRL_RST}, rd);
        close_out();
    end
endmodule : clk_pm_ctrl_bench

`default_nettype wire
